// ===== rtl/sfi_pkg.sv
// shared constants and types for the serial flash instruction framing block
package sfi_pkg;

  // opcodes handled by the framing logic
  localparam logic [7:0] OP_IDLE = 8'h00;             // idle_cmd
  localparam logic [7:0] OP_ARM = 8'h66;              // soft_reset_arm_cmd
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;       // executes only when armed
  localparam logic [7:0] OP_ENTER_NIBBLE = 8'h38;     // enter_nibble_mode_cmd
  localparam logic [7:0] OP_LEAVE_NIBBLE = 8'hFF;     // back to single-bit mode
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;     // sector_erase_cmd
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;      // block_erase_cmd
  localparam logic [7:0] OP_WIDE_PAGE_WRITE = 8'h32;  // wide_page_write_cmd
  localparam logic [7:0] OP_WAKE_READ_ID = 8'hAB;     // wake_and_read_id_cmd

  // serial clock edges per framing unit
  localparam int CNT_W = 12;                           // saturating edge counter width
  localparam logic [11:0] SER_OP_EDGES = 12'h008;     // opcode, single-bit mode
  localparam logic [11:0] QUAD_OP_EDGES = 12'h002;    // opcode, nibble mode
  localparam logic [11:0] SER_HDR_EDGES = 12'h020;    // opcode plus 3 address bytes
  localparam logic [11:0] QUAD_HDR_EDGES = 12'h008;   // opcode plus 3 address bytes
  localparam logic [11:0] CNT_MAX = 12'hFFF;          // counter saturates here
  localparam logic [11:0] PAGE_MAX_BYTES = 12'h100;   // 256 data bytes per page write

  // erase granularity, lowest decoded address bit
  localparam int SECTOR_LSB = 12;
  localparam int BLK64_LSB = 16;
  localparam int BLK32_LSB = 15;
  localparam int BLK8_LSB = 13;
  localparam logic [23:0] ADDR_ONES = 24'hFFFFFF;

  // reset values
  localparam logic CS_IDLE = 1'b1;                     // chip select idles high
  localparam logic QUAD_RESET = 1'b0;                  // power up in single-bit mode

  // link side state kept across frames
  typedef struct packed {
    logic quad;          // nibble mode active
    logic arm;           // soft reset armed
    logic fq;            // mode the current frame was sent in
    logic sres;          // soft reset executed in this frame
    logic seq;           // toggles at each frame start
    logic [11:0] cnt;    // edges seen in this frame
    logic [31:0] hdr;    // opcode and address
  } sfi_keep_t;

  // link side state cleared whenever chip select is high
  typedef struct packed {
    logic live;          // at least one edge seen in this frame
    logic [3:0] oe;      // pin drive enables
    logic [3:0] dout;    // pin output values
    logic [7:0] osh;     // identifier rotator
  } sfi_frm_t;

  // system side state
  typedef struct packed {
    logic [2:0] cs_s;    // chip select synchroniser
    logic [2:0] seq_s; // frame sequence synchroniser, same depth as chip select
    logic seq_seen;      // last frame sequence decoded
    logic sec_req;
    logic blk_req;
    logic pp_req;
    logic wake_req;
    logic sres;
    logic reject;
    logic quad;
    logic [23:0] addr;
    logic [8:0] pp_len;
  } sfi_sys_t;

endpackage

// ===== rtl/sfi_frame_decoder.sv
// instruction framing and decode for the serial flash host interface
//
// Overview of operation
// RULE1: opcode takes two clocks quad, eight single
// RULE2: address and data bytes: two or eight clocks
// RULE3: address bits above density are ignored
// RULE4: soft reset runs only straight after arm
// RULE5: wide page write needs pin config bit
// RULE6: wide page write 32H, single mode, 1-256
// RULE7: sector erase 20H, three address bytes
// RULE8: sector picked by top bits down to A12
// RULE9: block erase D8H, three address bytes
// RULE10: block decoded to A16, A15 or A13
// RULE11: wake ABH, three address bytes, streams identifier
// RULE12: enter-nibble command switches all later frames
// RULE13: config bit turns protect/hold into data; nibble mode reads and drives them whatever the bit
// RULE14: idle command only cancels armed reset
// RULE15: host frames commands on byte boundaries
`timescale 1ns/1ps
module sfi_frame_decoder #(
  parameter int ADDR_W = 21,                  // address bits the density needs
  parameter logic [7:0] ID_BYTE = 8'h5A       // identifier byte, value is arbitrary
) (
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link pins from the host controller
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe,
  // configuration level from the register owner
  input wire logic quad_pin_config_bit,
  // decoded requests, one ref_clk pulse each; target address and page length hold their last value
  output logic sector_erase_req,
  output logic block_erase_req,
  output logic page_write_req,
  output logic wake_req,
  output logic soft_reset_pulse,
  output logic cmd_reject,
  output logic [23:0] target_addr,
  output logic [8:0] page_write_len,
  // status
  output logic quad_mode
);

  // refuse densities the erase block map cannot serve
  if (ADDR_W < 17 || ADDR_W > 23) begin : g_bad_width
    $error("sfi_frame_decoder: ADDR_W must lie in 17..23");
  end

  // ---------------- link domain ----------------
  sfi_pkg::sfi_keep_t k_r, k_nxt;
  sfi_pkg::sfi_frm_t f_r, f_nxt;
  logic frm_rst_b;                     // frame state clears while deselected
  logic [11:0] cnt_base;               // edge count before this edge
  logic fq_now;                        // mode of the running frame
  logic op_done;                       // this edge completes the opcode
  logic hdr_done;                      // this edge completes the address
  logic [7:0] op_now;                  // opcode as seen at op_done

  assign frm_rst_b = rst_b & ~cs_b;

  // next state of the link side, one step per rising serial clock
  always_comb begin
    k_nxt = k_r;
    f_nxt = f_r;
    f_nxt.live = 1'b1;
    // first edge of a frame restarts the count and latches the mode
    cnt_base = f_r.live ? k_r.cnt : 12'h000;
    fq_now = f_r.live ? k_r.fq : k_r.quad;
    k_nxt.fq = fq_now;
    if (!f_r.live) begin
      k_nxt.sres = 1'b0;
      k_nxt.seq = ~k_r.seq;
    end
    k_nxt.cnt = (cnt_base == sfi_pkg::CNT_MAX) ? cnt_base : cnt_base + 12'h001;
    // header shift: a nibble per edge in quad, a bit per edge otherwise
    if (fq_now && cnt_base < sfi_pkg::QUAD_HDR_EDGES) begin
      k_nxt.hdr = {k_r.hdr[27:0], sio_in}; // RULE1 RULE2
    end else if (!fq_now && cnt_base < sfi_pkg::SER_HDR_EDGES) begin
      k_nxt.hdr = {k_r.hdr[30:0], sio_in[0]}; // RULE1 RULE2
    end
    op_done = fq_now ? (k_nxt.cnt == sfi_pkg::QUAD_OP_EDGES)
                     : (k_nxt.cnt == sfi_pkg::SER_OP_EDGES); // RULE1
    hdr_done = fq_now ? (k_nxt.cnt == sfi_pkg::QUAD_HDR_EDGES)
                      : (k_nxt.cnt == sfi_pkg::SER_HDR_EDGES); // RULE2
    op_now = k_nxt.hdr[7:0];
    // mode and reset guard act as soon as the opcode is complete
    if (op_done) begin
      k_nxt.arm = 1'b0; // RULE4 RULE14
      unique case (op_now)
        sfi_pkg::OP_ARM: begin
          k_nxt.arm = 1'b1; // RULE4
        end
        sfi_pkg::OP_SOFT_RESET: begin
          if (k_r.arm) begin
            k_nxt.quad = sfi_pkg::QUAD_RESET; // RULE4
            k_nxt.sres = 1'b1;
          end
        end
        sfi_pkg::OP_ENTER_NIBBLE: begin
          // only honoured in single-bit mode
          if (!fq_now) begin
            k_nxt.quad = 1'b1; // RULE12
          end
        end
        sfi_pkg::OP_LEAVE_NIBBLE: begin
          k_nxt.quad = sfi_pkg::QUAD_RESET;
        end
        default: begin
          // idle and all other opcodes leave the mode alone
        end
      endcase
    end
    // identifier output: rotate so the byte repeats while the clock runs
    if (hdr_done && k_nxt.hdr[31:24] == sfi_pkg::OP_WAKE_READ_ID) begin
      f_nxt.oe = fq_now ? 4'hF : 4'h2; // RULE11 RULE13
      f_nxt.dout = fq_now ? ID_BYTE[7:4] : {2'h0, ID_BYTE[7], 1'b0};
      f_nxt.osh = fq_now ? {ID_BYTE[3:0], ID_BYTE[7:4]} : {ID_BYTE[6:0], ID_BYTE[7]};
    end else if (f_r.oe != 4'h0) begin
      f_nxt.dout = fq_now ? f_r.osh[7:4] : {2'h0, f_r.osh[7], 1'b0}; // RULE11
      f_nxt.osh = fq_now ? {f_r.osh[3:0], f_r.osh[7:4]} : {f_r.osh[6:0], f_r.osh[7]};
    end
  end

  // persistent link state: kept after the frame so the system side can read it
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      k_r <= '{quad: sfi_pkg::QUAD_RESET, arm: 1'b0, fq: 1'b0, sres: 1'b0,
               seq: 1'b0, cnt: 12'h000, hdr: 32'h0000_0000};
    end else begin
      k_r <= k_nxt;
    end
  end

  // frame state: chip select high releases the pins without a clock edge
  always_ff @(posedge sclk or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      f_r <= '{live: 1'b0, oe: 4'h0, dout: 4'h0, osh: 8'h00};
    end else begin
      f_r <= f_nxt;
    end
  end

  assign sio_out = f_r.dout;
  assign sio_oe = f_r.oe;

  // ---------------- system domain ----------------
  sfi_pkg::sfi_sys_t s_r, s_nxt;
  logic frame_end;                    // accepted rising chip select
  logic [11:0] hdr_edges;             // header length of the finished frame
  logic hdr_ok;                       // all three address bytes arrived
  logic nib_data;                     // data moved two clocks per byte
  logic [11:0] dcnt;                  // data edges after the header
  logic aligned;                      // frame ended on a byte boundary
  logic [11:0] nbytes;                // whole data bytes
  logic [23:0] addr_m;                // address cut to the density
  logic [7:0] op_f;                   // opcode of the finished frame
  logic [11:0] op_edges; // opcode length in the frame's mode
  logic [11:0] hdr_seen; // header edges that arrived
  logic [11:0] op_sh; // bit position of the opcode in the header

  // block size depends on location: parameter blocks at both ends
  function automatic logic [23:0] blk_base(input logic [23:0] a);
    logic lo;
    logic hi;
    logic [23:0] m;
    lo = (a[ADDR_W-1:sfi_pkg::BLK64_LSB] == '0);
    hi = (&a[ADDR_W-1:sfi_pkg::BLK64_LSB]);
    if ((lo && !a[sfi_pkg::BLK32_LSB]) || (hi && a[sfi_pkg::BLK32_LSB])) begin
      m = sfi_pkg::ADDR_ONES << sfi_pkg::BLK8_LSB; // RULE10
    end else if (lo || hi) begin
      m = sfi_pkg::ADDR_ONES << sfi_pkg::BLK32_LSB; // RULE10
    end else begin
      m = sfi_pkg::ADDR_ONES << sfi_pkg::BLK64_LSB; // RULE10
    end
    return a & m;
  endfunction

  // decode a finished frame; the link clock is idle while chip select is
  // high, so the link state read here is stable for the whole decode
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_s = {s_r.cs_s[1:0], cs_b};
    s_nxt.sec_req = 1'b0;
    s_nxt.blk_req = 1'b0;
    s_nxt.pp_req = 1'b0;
    s_nxt.wake_req = 1'b0;
    s_nxt.sres = 1'b0;
    s_nxt.reject = 1'b0;
    s_nxt.seq_s = {s_r.seq_s[1:0], k_r.seq};
    addr_m = k_r.hdr[23:0] & ~(sfi_pkg::ADDR_ONES << ADDR_W); // RULE3
    hdr_edges = k_r.fq ? sfi_pkg::QUAD_HDR_EDGES : sfi_pkg::SER_HDR_EDGES;
    hdr_ok = (k_r.cnt >= hdr_edges);
    // the opcode sits just above the address units that arrived; bits left
    // over from an earlier frame fall off the top, so a short frame never
    // decodes a stale opcode
    op_edges = k_r.fq ? sfi_pkg::QUAD_OP_EDGES : sfi_pkg::SER_OP_EDGES;
    hdr_seen = hdr_ok ? hdr_edges : k_r.cnt;
    op_sh = k_r.fq ? ({hdr_seen[9:0], 2'b00} - 12'h008) : (hdr_seen - 12'h008);
    op_f = (k_r.cnt >= op_edges) ? 8'(k_r.hdr >> op_sh) : sfi_pkg::OP_IDLE;
    nib_data = k_r.fq || (op_f == sfi_pkg::OP_WIDE_PAGE_WRITE); // RULE2 RULE5
    dcnt = hdr_ok ? (k_r.cnt - hdr_edges) : 12'h000;
    aligned = nib_data ? (dcnt[0] == 1'b0) : (dcnt[2:0] == 3'h0); // RULE15
    nbytes = nib_data ? (dcnt >> 1) : (dcnt >> 3);
    // the sequence flips only after chip select fell, so a settled new
    // sequence seen with chip select settled high means the frame is over;
    // a frame shorter than a system clock would slip past a level detector
    frame_end = s_r.cs_s[1] && s_r.cs_s[2] && (s_r.seq_s[1] == s_r.seq_s[2])
                && (s_r.seq_s[2] != s_r.seq_seen);
    if (frame_end) begin
      s_nxt.seq_seen = s_r.seq_s[2];
      s_nxt.quad = k_r.quad; // RULE12
      s_nxt.sres = k_r.sres; // RULE4
      unique case (op_f)
        sfi_pkg::OP_SECTOR_ERASE: begin
          if (hdr_ok && dcnt == 12'h000) begin
            s_nxt.sec_req = 1'b1; // RULE7
            s_nxt.addr = addr_m & (sfi_pkg::ADDR_ONES << sfi_pkg::SECTOR_LSB); // RULE8
          end else begin
            s_nxt.reject = 1'b1;
          end
        end
        sfi_pkg::OP_BLOCK_ERASE: begin
          if (hdr_ok && dcnt == 12'h000) begin
            s_nxt.blk_req = 1'b1; // RULE9
            s_nxt.addr = blk_base(addr_m); // RULE10
          end else begin
            s_nxt.reject = 1'b1;
          end
        end
        sfi_pkg::OP_WIDE_PAGE_WRITE: begin
          // single-bit mode only, and protect/hold must be data pins
          if (!k_r.fq && quad_pin_config_bit && hdr_ok && aligned // RULE5 RULE13
              && nbytes != 12'h000 && nbytes <= sfi_pkg::PAGE_MAX_BYTES) begin
            s_nxt.pp_req = 1'b1; // RULE6
            s_nxt.addr = addr_m;
            s_nxt.pp_len = nbytes[8:0];
          end else begin
            s_nxt.reject = 1'b1;
          end
        end
        sfi_pkg::OP_WAKE_READ_ID: begin
          if (hdr_ok && aligned) begin
            s_nxt.wake_req = 1'b1; // RULE11
            s_nxt.addr = addr_m;
          end else begin
            s_nxt.reject = 1'b1;
          end
        end
        default: begin
          // other opcodes belong to other blocks
        end
      endcase
    end
  end

  // system register: chip select synchroniser plus the request pulses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{cs_s: {3{sfi_pkg::CS_IDLE}}, seq_s: 3'h0, seq_seen: 1'b0,
               sec_req: 1'b0, blk_req: 1'b0, pp_req: 1'b0, wake_req: 1'b0,
               sres: 1'b0, reject: 1'b0, quad: sfi_pkg::QUAD_RESET,
               addr: 24'h000000, pp_len: 9'h000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sector_erase_req = s_r.sec_req;
  assign block_erase_req = s_r.blk_req;
  assign page_write_req = s_r.pp_req;
  assign wake_req = s_r.wake_req;
  assign soft_reset_pulse = s_r.sres;
  assign cmd_reject = s_r.reject;
  assign target_addr = s_r.addr;
  assign page_write_len = s_r.pp_len;
  assign quad_mode = s_r.quad;

  // ---------------- checks ----------------
  a_sector_low_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
    s_r.sec_req |-> s_r.addr[11:0] == 12'h000)
    else $error("sector erase address not sector aligned");

  a_block_low_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
    s_r.blk_req |-> s_r.addr[12:0] == 13'h0000 && !s_r.sec_req)
    else $error("block erase address not block aligned");

  a_top_bits_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
    (s_r.sec_req || s_r.blk_req || s_r.pp_req || s_r.wake_req)
      |-> (s_r.addr >> ADDR_W) == 24'h000000)
    else $error("address bits above density leaked");

  a_page_len_range: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
    s_r.pp_req |-> s_r.pp_len != 9'h000 && !$past(k_r.fq) && $past(op_f) == 8'h32)
    else $error("wide page write with bad length or mode");

  a_page_needs_cfg: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
    s_r.pp_req |-> $past(quad_pin_config_bit))
    else $error("wide page write accepted without pin config bit");

  a_reset_needs_arm: assert property (@(posedge sclk) disable iff (!rst_b) // RULE4
    $rose(k_r.sres) |-> $past(k_r.arm) && $past(k_r.cnt) == $past(cnt_base))
    else $error("soft reset executed while not armed");

  a_nibble_entry: assert property (@(posedge sclk) disable iff (!rst_b) // RULE12
    $rose(k_r.quad) |-> $past(k_r.cnt) == 12'h007 && !k_r.fq && k_r.hdr[7:0] == 8'h38)
    else $error("nibble mode entered without eight clock opcode");

  a_idle_cancels: assert property (@(posedge sclk) disable iff (!rst_b) // RULE14
    (op_done && op_now == 8'h00) |=> !k_r.arm && k_r.quad == $past(k_r.quad))
    else $error("idle command changed more than the reset arm");

  a_quad_opcode_len: assert property (@(posedge sclk) disable iff (!rst_b) // RULE1
    (op_done && fq_now) |=> k_r.cnt == 12'h002 && k_r.fq)
    else $error("nibble opcode not two clocks");

endmodule

// ===== sim/sfi_host_model.sv
// host controller model that frames instructions on the serial flash link
`timescale 1ns/1ps
module sfi_host_model (
  // link pins toward the device
  output logic sclk,
  output logic cs_b,
  output logic [3:0] sio_in,
  // device answer
  input wire logic [3:0] sio_out,
  input wire logic [3:0] sio_oe
);
  // link clock stands still low between frames
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sio_in = 4'h0;
  end
  // one 6 ns link clock, data set while the clock is low
  task automatic edge_out(input logic [3:0] d);
    sio_in = d;
    #3 sclk = 1'b1;
    #3 sclk = 1'b0;
  endtask
  // one byte, msb or ms nibble first; unused lines held at a valid low
  task automatic send_byte(input logic [7:0] b, input bit wide);
    if (wide) begin
      edge_out(b[7:4]);
      edge_out(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        edge_out({3'h0, b[i]});
      end
    end
  endtask
  // opcode, address, data, stray edges, then read-back samples
  task automatic frame(input bit q, input logic [7:0] op, input int na,
    input logic [23:0] a, input int nd, input bit dq, input int tail, input int nrd,
    output logic [15:0] rd, output logic [3:0] oe_seen);
    rd = 16'h0;
    oe_seen = 4'h0;
    #5 cs_b = 1'b0;
    send_byte(op, q);
    for (int i = 0; i < na; i++) begin
      send_byte(a[23-8*i -: 8], q);
    end
    for (int i = 0; i < nd; i++) begin
      send_byte(i[7:0], dq);
    end
    // stray edges break the byte boundary on purpose
    for (int i = 0; i < tail; i++) begin
      edge_out(4'h0);
    end
    // sample just after each falling edge, output launched on the rise
    for (int i = 0; i < nrd; i++) begin
      oe_seen = sio_oe;
      rd = q ? {rd[11:0], sio_out} : {rd[14:0], sio_out[1]};
      edge_out(4'h0);
    end
    #3 cs_b = 1'b1;
    sio_in = ~sio_in; // a released line must not keep its last level
    #1000;
  endtask
endmodule

// ===== sim/sfi_frame_decoder_test.sv
// self-checking testbench for the serial flash instruction framing block
`timescale 1ns/1ps
module sfi_frame_decoder_test;
  localparam logic [7:0] ID = 8'hC3; // identifier byte, value is arbitrary
  logic ref_clk, rst_b, cfg, sclk, cs_b;
  logic [3:0] sio_in, sio_out, sio_oe, oes;
  logic sec, blk, pp, wake, srst, rej, qm;
  logic [23:0] addr;
  logic [8:0] plen;
  logic [15:0] rd;
  int failures, samples_checked, cycles;
  int n_sec, n_blk, n_pp, n_wake, n_srst, n_rej;
  // system clock, 100 ns
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  sfi_frame_decoder #(.ADDR_W(21), .ID_BYTE(ID)) i_sfi_frame_decoder (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe), .quad_pin_config_bit(cfg),
    .sector_erase_req(sec), .block_erase_req(blk), .page_write_req(pp),
    .wake_req(wake), .soft_reset_pulse(srst), .cmd_reject(rej),
    .target_addr(addr), .page_write_len(plen), .quad_mode(qm));
  sfi_host_model i_sfi_host_model (.sclk(sclk), .cs_b(cs_b), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe));
  // count request pulses where they are settled
  always @(negedge ref_clk) begin
    n_sec += (sec === 1'b1);
    n_blk += (blk === 1'b1);
    n_pp += (pp === 1'b1);
    n_wake += (wake === 1'b1);
    n_srst += (srst === 1'b1);
    n_rej += (rej === 1'b1);
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pulse counts as nibbles: sector, block, page, wake, reset, reject
  function automatic logic [23:0] evts();
    return {n_sec[3:0], n_blk[3:0], n_pp[3:0], n_wake[3:0], n_srst[3:0], n_rej[3:0]};
  endfunction
  // one frame with fresh counters; the model's gap covers decode latency
  task automatic run(input bit q, input logic [7:0] op, input int na, input logic [23:0] a,
    input int nd, input bit dq, input int tail, input int nrd);
    {n_sec, n_blk, n_pp, n_wake, n_srst, n_rej} = '0;
    i_sfi_host_model.frame(q, op, na, a, nd, dq, tail, nrd, rd, oes);
  endtask
  task automatic t_sector();
    run(0, sfi_pkg::OP_SECTOR_ERASE, 3, 24'h012345, 0, 0, 0, 0);
    check(evts(), 24'h100000);
    check(addr, 24'h012000);
    run(0, sfi_pkg::OP_SECTOR_ERASE, 3, 24'hE1FFFF, 0, 0, 0, 0);
    check(addr, 24'h01F000);
    run(0, sfi_pkg::OP_SECTOR_ERASE, 3, 24'h012345, 0, 0, 4, 0);
    check(evts(), 24'h000001);
    run(0, sfi_pkg::OP_SECTOR_ERASE, 2, 24'h012345, 0, 0, 0, 0);
    check(evts(), 24'h000001);
  endtask
  task automatic t_block();
    logic [23:0] ain [5] = '{24'h0A5678, 24'h003456, 24'h00B456, 24'h1FF123, 24'h1F4567};
    logic [23:0] aex [5] = '{24'h0A0000, 24'h002000, 24'h008000, 24'h1FE000, 24'h1F0000};
    for (int i = 0; i < 5; i++) begin
      run(0, sfi_pkg::OP_BLOCK_ERASE, 3, ain[i], 0, 0, 0, 0);
      check(evts(), 24'h010000);
      check(addr, aex[i]);
    end
  endtask
  task automatic t_page();
    @(negedge ref_clk) cfg = 1'b1;
    run(0, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h000100, 1, 1, 0, 0);
    check(evts(), 24'h001000);
    check(plen, 9'h001);
    run(0, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h000100, 256, 1, 0, 0);
    check(plen, 9'h100);
    run(0, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h000100, 257, 1, 0, 0);
    check(evts(), 24'h000001);
    run(0, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h000100, 0, 1, 0, 0);
    check(evts(), 24'h000001);
    @(negedge ref_clk) cfg = 1'b0;
    run(0, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h000100, 1, 1, 0, 0);
    check(evts(), 24'h000001);
  endtask
  task automatic t_nibble();
    @(negedge ref_clk) cfg = 1'b1;
    run(0, sfi_pkg::OP_ENTER_NIBBLE, 0, 24'h0, 0, 0, 0, 0);
    check(qm, 1'b1);
    run(1, sfi_pkg::OP_BLOCK_ERASE, 3, 24'h0A5678, 0, 0, 0, 0);
    check(addr, 24'h0A0000);
    run(1, sfi_pkg::OP_WIDE_PAGE_WRITE, 3, 24'h0, 1, 1, 0, 0);
    check(evts(), 24'h000001);
    run(1, sfi_pkg::OP_WAKE_READ_ID, 3, 24'h0, 0, 0, 0, 4);
    check({rd, oes}, {ID, ID, 4'hF});
    run(1, sfi_pkg::OP_LEAVE_NIBBLE, 0, 24'h0, 0, 0, 0, 0);
    check(qm, 1'b0);
    run(0, sfi_pkg::OP_WAKE_READ_ID, 3, 24'h0, 0, 0, 0, 16);
    check({rd, oes, evts()}, {ID, ID, 4'h2, 24'h000100});
    check(sio_oe, 4'h0);
  endtask
  task automatic t_reset();
    // leaves a wake opcode where a short frame's stale header byte would sit
    run(0, sfi_pkg::OP_SECTOR_ERASE, 3, 24'hAB0000, 0, 0, 0, 0);
    check(addr, 24'h0B0000);
    run(0, sfi_pkg::OP_ARM, 0, 24'h0, 0, 0, 0, 0);
    check(evts(), 24'h000000);
    run(0, sfi_pkg::OP_SOFT_RESET, 0, 24'h0, 0, 0, 0, 0);
    check(evts(), 24'h000010);
    run(0, sfi_pkg::OP_ARM, 0, 24'h0, 0, 0, 0, 0);
    run(0, sfi_pkg::OP_IDLE, 0, 24'h0, 0, 0, 0, 0);
    check(evts(), 24'h000000);
    run(0, sfi_pkg::OP_SOFT_RESET, 0, 24'h0, 0, 0, 0, 0);
    check(evts(), 24'h000000);
    run(0, sfi_pkg::OP_ENTER_NIBBLE, 0, 24'h0, 0, 0, 0, 0);
    run(1, sfi_pkg::OP_ARM, 0, 24'h0, 0, 0, 0, 0);
    run(1, sfi_pkg::OP_SOFT_RESET, 0, 24'h0, 0, 0, 0, 0);
    check({qm, evts()}, {1'b0, 24'h000010});
    // hardware reset in mid-run drops nibble mode and the address
    run(0, sfi_pkg::OP_ENTER_NIBBLE, 0, 24'h0, 0, 0, 0, 0);
    @(negedge ref_clk) rst_b = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    check({qm, addr}, 25'h0);
    // the link must frame single-bit again after the hardware reset
    run(0, sfi_pkg::OP_SECTOR_ERASE, 3, 24'h012345, 0, 0, 0, 0);
    check({qm, addr, evts()}, {1'b0, 24'h012000, 24'h100000});
  endtask
  // reset for 6 cycles, then every scenario in turn
  initial begin
    rst_b = 1'b0;
    cfg = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_sector();
    t_block();
    t_page();
    t_nibble();
    t_reset();
    summarize();
  end
endmodule
